// [verilog/dio_issuer.sv]
// Direct I/O command issuer: executes direct I/O and interrupt instructions on
// the shared parallel I/O bus and returns a condition code and stack effects.
// Assumes an AHB-Lite master with single word transfers and controllers that
// answer with ack on the same clock.
//
// Overview of operation
// (R1) Device number from low byte at S-K.
// (R2) Read word: ready bit1, push data, equal.
// (R3) Not ready: push status, greater, no transfer.
// (R4) No response: less, stack untouched.
// (R5) Write word: ready bit1, send, pop, equal.
// (R6) Start: store top at 4*dev, pop, equal.
// (R7) Start readiness uses status bit 0.
// (R8) Control: send word; ack pops, else less.
// (R9) Mask broadcast to all controllers.
// (R10) Mask not acked: clear external bit, less.
// (R11) Mask acked: copy mask, pop, equal.
// (R12) Test status: push status, equal, else less.
// (R13) Set interrupt: equal, else less.
// (R14) Three-line command encoding as listed.
// (R15) Controller clears active, keeps cause state.
// (R16) Control, mask, test, setint need privilege.
// (R17) Start controllers check odd device parity; no device parity is driven on the bus.
// (R18) Multiplexer diagnostic device number is 127.
// (R19) Service needs mask, external bit, priority.
// (R20) No ack within timeout means no response.
// (R21) Drive select, data word and parity.
`timescale 1ns/10ps
module dio_issuer #(
	parameter int ACK_CYCLES = dio_pkg::DIO_ACK_TIMEOUT_CYC
) (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic hsel,
	input wire logic hready,
	input wire logic [31:0] hwdata,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	output dio_pkg::dio_bus_out_t bus_out,
	input wire dio_pkg::dio_bus_in_t bus_in,
	output logic ext_int_enable
);

	////////////////////////////////////////////////////////////////////////
	// Sequencer states.
	typedef enum logic [4:0] {
		DIO_ST_IDLE = 5'b00001,
		DIO_ST_TEST = 5'b00010,
		DIO_ST_XFER = 5'b00100,
		DIO_ST_WAIT = 5'b01000,
		DIO_ST_DONE = 5'b10000
	} dio_state_t;

	dio_state_t state; // Current state.
	dio_state_t next_state; // Next state.

	// Software-visible registers.
	dio_pkg::dio_op_t op; // Selected operation.
	logic priv; // Privileged mode.
	logic [15:0] stack_top; // Word at top of stack.
	logic [15:0] stack_k; // Word at S-K.
	logic [1:0] cc; // Condition code.
	logic busy; // Instruction in progress.
	logic pop; // Top was popped.
	logic push_valid; // A word was pushed.
	logic [15:0] push_word; // The pushed word.
	logic [15:0] mask_copy_register; // Copy of last accepted mask.
	logic [15:0] table_addr; // Table word address written by start.
	logic [15:0] table_data; // Program address stored there.
	logic [15:0] status_word; // Captured status.

	// AHB-Lite data-phase capture.
	logic wr_pend; // Write data phase pending.
	logic [7:0] wr_off; // Offset of the pending write.

	////////////////////////////////////////////////////////////////////////
	// Bus decode, kept as named wires.
	wire addr_ok = hsel && hready && htrans[1];
	wire [7:0] a_off = haddr[7:0];
	wire go_write = wr_pend && (wr_off == dio_pkg::DIO_OFF_CMD) && hwdata[dio_pkg::DIO_CMD_GO_BIT];
	wire [2:0] go_op = hwdata[dio_pkg::DIO_CMD_OP_LSB +: 3];
	wire [7:0] dev_no = stack_k[7:0]; // R1
	wire needs_priv = (op == dio_pkg::DIO_OP_CONTROL) || (op == dio_pkg::DIO_OP_MASK) ||
		(op == dio_pkg::DIO_OP_TEST) || (op == dio_pkg::DIO_OP_SETINT); // R16
	wire uses_ready = (op == dio_pkg::DIO_OP_READ) || (op == dio_pkg::DIO_OP_WRITE) ||
		(op == dio_pkg::DIO_OP_START);
	wire ready_bit = (op == dio_pkg::DIO_OP_START) ?
		bus_in.bus_data_lines[dio_pkg::DIO_RDY_START_BIT] : // R7
		bus_in.bus_data_lines[dio_pkg::DIO_RDY_DATA_BIT]; // R2 R5
	wire timed_out;
	wire waiting = (state == DIO_ST_TEST) || (state == DIO_ST_XFER);
	// The timer restarts whenever a fresh command goes on the bus. Without this a
	// slow readiness answer would eat into the time the transfer command gets,
	// and a healthy but slow controller could be reported as silent.
	wire timer_restart = (state == DIO_ST_IDLE) || (state == DIO_ST_TEST && bus_in.ack); // R20

	// Command code for the transfer phase of each operation.
	logic [2:0] xfer_cmd;
	always_comb begin
		unique case (op)
			dio_pkg::DIO_OP_READ: xfer_cmd = dio_pkg::DIO_CMD_READ;
			dio_pkg::DIO_OP_WRITE: xfer_cmd = dio_pkg::DIO_CMD_WRITE;
			dio_pkg::DIO_OP_START: xfer_cmd = dio_pkg::DIO_CMD_START;
			dio_pkg::DIO_OP_CONTROL: xfer_cmd = dio_pkg::DIO_CMD_CONTROL;
			dio_pkg::DIO_OP_MASK: xfer_cmd = dio_pkg::DIO_CMD_MASK;
			dio_pkg::DIO_OP_TEST: xfer_cmd = dio_pkg::DIO_CMD_TEST;
			dio_pkg::DIO_OP_SETINT: xfer_cmd = dio_pkg::DIO_CMD_SETINT;
			default: xfer_cmd = dio_pkg::DIO_CMD_TEST;
		endcase
	end

	// Mask goes to every controller; select the multiplexer address for it.
	wire [7:0] sel_dev = (op == dio_pkg::DIO_OP_MASK) ? dio_pkg::DIO_MUX_DEVICE_SELECT : dev_no; // R18
	wire [15:0] out_word = stack_top; // R21

	////////////////////////////////////////////////////////////////////////
	// Acknowledge timeout.
	dio_ack_timer #(
		.CYCLES(ACK_CYCLES)
	) u_timer (
		.clk_sys(clk_sys),
		.rst(rst),
		.start(timer_restart),
		.run(waiting && !bus_in.ack),
		.expired(timed_out)
	);

	////////////////////////////////////////////////////////////////////////
	// Next-state logic.
	always_comb begin
		next_state = state;
		unique case (state)
			DIO_ST_IDLE: if (go_write) next_state = DIO_ST_WAIT;
			DIO_ST_WAIT: begin
				// Privilege fail ends at once; readiness ops test first.
				if (needs_priv && !priv) next_state = DIO_ST_DONE; // R16
				else if (uses_ready) next_state = DIO_ST_TEST;
				else next_state = DIO_ST_XFER;
			end
			DIO_ST_TEST: begin
				if (bus_in.ack && ready_bit) next_state = DIO_ST_XFER;
				else if (bus_in.ack || timed_out) next_state = DIO_ST_DONE; // R3 R20
			end
			DIO_ST_XFER: if (bus_in.ack || timed_out) next_state = DIO_ST_DONE; // R20
			DIO_ST_DONE: next_state = DIO_ST_IDLE;
		endcase
	end

	always_ff @(posedge clk_sys) begin
		if (rst) state <= DIO_ST_IDLE;
		else state <= next_state;
	end

	////////////////////////////////////////////////////////////////////////
	// I/O bus drive: test command during readiness, operation command after.
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			bus_out <= '0;
		end else begin
			bus_out.strobe <= (next_state == DIO_ST_TEST) || (next_state == DIO_ST_XFER);
			bus_out.bus_command_code <= (next_state == DIO_ST_XFER) ? xfer_cmd : dio_pkg::DIO_CMD_TEST; // R14
			bus_out.device_select <= sel_dev; // R1 R21
			bus_out.bus_data_lines <= out_word; // R9 R21
			bus_out.bus_data_parity <= ~(^out_word); // R21
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Instruction results: condition code, stack effects, mask and table.
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			cc <= dio_pkg::DIO_CC_NONE;
			busy <= 1'b0;
			pop <= 1'b0;
			push_valid <= 1'b0;
			push_word <= 16'h0000;
			mask_copy_register <= dio_pkg::DIO_MASK_RESET;
			ext_int_enable <= dio_pkg::DIO_EXT_RESET;
			table_addr <= 16'h0000;
			table_data <= 16'h0000;
			status_word <= 16'h0000;
		end else begin
			if (go_write && state == DIO_ST_IDLE) begin
				busy <= 1'b1;
				cc <= dio_pkg::DIO_CC_NONE;
				pop <= 1'b0;
				push_valid <= 1'b0;
			end
			if (state == DIO_ST_WAIT && needs_priv && !priv) cc <= dio_pkg::DIO_CC_LESS; // R16
			if (state == DIO_ST_TEST) begin
				if (bus_in.ack && !ready_bit) begin
					push_valid <= 1'b1; // R3
					push_word <= bus_in.bus_data_lines;
					cc <= dio_pkg::DIO_CC_GREATER;
				end else if (!bus_in.ack && timed_out) begin
					cc <= dio_pkg::DIO_CC_LESS; // R4
				end
				if (bus_in.ack) status_word <= bus_in.bus_data_lines;
			end
			if (state == DIO_ST_XFER && timed_out && !bus_in.ack) begin
				cc <= dio_pkg::DIO_CC_LESS; // R4 R8 R12 R13
				if (op == dio_pkg::DIO_OP_MASK) ext_int_enable <= 1'b0; // R10
			end
			if (state == DIO_ST_XFER && bus_in.ack) begin
				cc <= dio_pkg::DIO_CC_EQUAL;
				unique case (op)
					dio_pkg::DIO_OP_READ, dio_pkg::DIO_OP_TEST: begin
						push_valid <= 1'b1; // R2 R12
						push_word <= bus_in.bus_data_lines;
					end
					dio_pkg::DIO_OP_START: begin
						table_addr <= {6'h00, dev_no, 2'h0}; // R6
						table_data <= stack_top;
						pop <= 1'b1;
					end
					dio_pkg::DIO_OP_MASK: begin
						mask_copy_register <= stack_top; // R11
						pop <= 1'b1;
					end
					dio_pkg::DIO_OP_WRITE, dio_pkg::DIO_OP_CONTROL: pop <= 1'b1; // R5 R8
					default: pop <= 1'b0; // R13
				endcase
			end
			if (state == DIO_ST_DONE) busy <= 1'b0;
			// Software may turn external interrupts back on from the command register.
			// The enable gates interrupt service, so it is only turned on between instructions.
			if (wr_pend && wr_off == dio_pkg::DIO_OFF_CMD && hwdata[dio_pkg::DIO_CMD_EXT_BIT] && !busy)
				ext_int_enable <= 1'b1; // R19
		end
	end

	////////////////////////////////////////////////////////////////////////
	// AHB-Lite slave: zero wait states, always OKAY.
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			wr_pend <= 1'b0;
			wr_off <= 8'h00;
			op <= dio_pkg::DIO_OP_READ;
			priv <= 1'b0;
			stack_top <= 16'h0000;
			stack_k <= 16'h0000;
		end else begin
			wr_pend <= addr_ok && hwrite;
			wr_off <= a_off;
			// Operands are locked while an instruction runs.
			if (wr_pend && !busy && !(state != DIO_ST_IDLE)) begin
				unique case (wr_off)
					dio_pkg::DIO_OFF_CMD: begin
						op <= dio_pkg::dio_op_t'(go_op);
						priv <= hwdata[dio_pkg::DIO_CMD_PRIV_BIT];
					end
					dio_pkg::DIO_OFF_STACK_TOP: stack_top <= hwdata[15:0];
					dio_pkg::DIO_OFF_STACK_K: stack_k <= hwdata[15:0];
					default: ;
				endcase
			end
		end
	end

	// Read data mux on the address-phase offset; unmapped offsets read as zero.
	// Decoding the live address lets the word be registered before the data phase.
	logic [31:0] next_hrdata;
	always_comb begin
		unique case (a_off)
			dio_pkg::DIO_OFF_CMD: next_hrdata = {26'h0, ext_int_enable, priv, 1'b0, op};
			dio_pkg::DIO_OFF_STACK_TOP: next_hrdata = {16'h0, stack_top};
			dio_pkg::DIO_OFF_STACK_K: next_hrdata = {16'h0, stack_k};
			dio_pkg::DIO_OFF_RESULT: next_hrdata = {12'h0, status_word, busy, pop, cc};
			dio_pkg::DIO_OFF_PUSH: next_hrdata = {15'h0, push_valid, push_word};
			dio_pkg::DIO_OFF_MASK: next_hrdata = {16'h0, mask_copy_register};
			dio_pkg::DIO_OFF_TABLE: next_hrdata = {table_addr, table_data};
			default: next_hrdata = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			hrdata <= 32'h0000_0000;
			hreadyout <= 1'b1;
			hresp <= 1'b0;
		end else begin
			// Read data is loaded at the end of the address phase so that it stands
			// through the whole data phase with no wait state; it then holds until
			// the next read, so a stray sample between transfers sees no glitch.
			if (addr_ok && !hwrite) hrdata <= next_hrdata;
			hreadyout <= 1'b1;
			hresp <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Assertions.
	no_ack_less_a: assert property (@(posedge clk_sys) disable iff (rst)
		(state == DIO_ST_XFER && timed_out && !bus_in.ack) |=> (cc == dio_pkg::DIO_CC_LESS)) // R4
		else $error("missing ack did not give less");
	not_ready_gt_a: assert property (@(posedge clk_sys) disable iff (rst)
		(state == DIO_ST_TEST && bus_in.ack && !ready_bit) |=> (cc == dio_pkg::DIO_CC_GREATER && push_valid)) // R3
		else $error("not ready did not push status");
	read_push_a: assert property (@(posedge clk_sys) disable iff (rst)
		(state == DIO_ST_XFER && bus_in.ack && op == dio_pkg::DIO_OP_READ) |=> (push_valid && cc == 2'h1)) // R2
		else $error("read did not push data");
	start_table_a: assert property (@(posedge clk_sys) disable iff (rst)
		(state == DIO_ST_XFER && bus_in.ack && op == dio_pkg::DIO_OP_START) |=> (table_addr == {6'h00, $past(dev_no), 2'h0} && pop)) // R6
		else $error("start table word wrong");
	mask_copy_a: assert property (@(posedge clk_sys) disable iff (rst)
		(state == DIO_ST_XFER && bus_in.ack && op == dio_pkg::DIO_OP_MASK) |=> (mask_copy_register == $past(stack_top))) // R11
		else $error("mask not copied");
	mask_fail_a: assert property (@(posedge clk_sys) disable iff (rst)
		(state == DIO_ST_XFER && timed_out && !bus_in.ack && op == dio_pkg::DIO_OP_MASK) |=> (!ext_int_enable && !pop)) // R10
		else $error("mask failure left interrupts on");
	priv_block_a: assert property (@(posedge clk_sys) disable iff (rst)
		(state == DIO_ST_WAIT && needs_priv && !priv) |=> (state == DIO_ST_DONE && !bus_out.strobe)) // R16
		else $error("privileged op ran in user mode");
	parity_odd_a: assert property (@(posedge clk_sys) disable iff (rst)
		bus_out.strobe |-> (^{bus_out.bus_data_lines, bus_out.bus_data_parity})) // R21
		else $error("data parity not odd");
	xfer_code_a: assert property (@(posedge clk_sys) disable iff (rst)
		(state == DIO_ST_XFER && op == dio_pkg::DIO_OP_WRITE) |-> (bus_out.bus_command_code == 3'h4)) // R14
		else $error("write command code wrong");
	// A mask broadcast must carry the multiplexer's fixed number, never a stale device.
	mask_select_a: assert property (@(posedge clk_sys) disable iff (rst) // R18
		(bus_out.strobe && bus_out.bus_command_code == dio_pkg::DIO_CMD_MASK) |->
		(bus_out.device_select == dio_pkg::DIO_MUX_DEVICE_SELECT))
		else $error("mask broadcast not sent to the multiplexer number");
	read_cov: cover property (@(posedge clk_sys) state == DIO_ST_XFER && bus_in.ack && op == dio_pkg::DIO_OP_READ);
	timeout_cov: cover property (@(posedge clk_sys) state == DIO_ST_TEST && timed_out);
	mask_cov: cover property (@(posedge clk_sys) state == DIO_ST_XFER && bus_in.ack && op == dio_pkg::DIO_OP_MASK);
	notready_cov: cover property (@(posedge clk_sys) state == DIO_ST_TEST && bus_in.ack && !ready_bit);

endmodule : dio_issuer

// [pkg/dio_pkg.sv]
// Package for the direct I/O command issuer: bus command codes, operation
// codes, condition codes, timing counts and the carrier structs.
// Assumes a single 125 MHz system clock and an AHB-Lite register port.
package dio_pkg;

	// Bus command codes driven on the three command lines.
	localparam logic [2:0] DIO_CMD_READ = 3'h0;
	localparam logic [2:0] DIO_CMD_MASK = 3'h1;
	localparam logic [2:0] DIO_CMD_TEST = 3'h2;
	localparam logic [2:0] DIO_CMD_CLRACT = 3'h3;
	localparam logic [2:0] DIO_CMD_WRITE = 3'h4;
	localparam logic [2:0] DIO_CMD_START = 3'h5;
	localparam logic [2:0] DIO_CMD_CONTROL = 3'h6;
	localparam logic [2:0] DIO_CMD_SETINT = 3'h7;

	// Condition code values.
	localparam logic [1:0] DIO_CC_NONE = 2'h0;
	localparam logic [1:0] DIO_CC_EQUAL = 2'h1;
	localparam logic [1:0] DIO_CC_GREATER = 2'h2;
	localparam logic [1:0] DIO_CC_LESS = 2'h3;

	// Register byte offsets.
	localparam logic [7:0] DIO_OFF_CMD = 8'h00;
	localparam logic [7:0] DIO_OFF_STACK_TOP = 8'h04;
	localparam logic [7:0] DIO_OFF_STACK_K = 8'h08;
	localparam logic [7:0] DIO_OFF_RESULT = 8'h0c;
	localparam logic [7:0] DIO_OFF_PUSH = 8'h10;
	localparam logic [7:0] DIO_OFF_MASK = 8'h14;
	localparam logic [7:0] DIO_OFF_TABLE = 8'h18;

	// Field positions inside the command register.
	localparam int DIO_CMD_OP_LSB = 0;
	localparam int DIO_CMD_PRIV_BIT = 4;
	localparam int DIO_CMD_EXT_BIT = 5;
	localparam int DIO_CMD_GO_BIT = 31;
	// Ready bits in the controller status word (bit 0 is the MSB).
	localparam int DIO_RDY_START_BIT = 15;
	localparam int DIO_RDY_DATA_BIT = 14;

	// Reset values.
	localparam logic [15:0] DIO_MASK_RESET = 16'h0000;
	localparam logic DIO_EXT_RESET = 1'b0;

	// Acknowledge timeout and the multiplexer diagnostic device number.
	localparam int DIO_CLK_MHZ = 125;
	localparam int DIO_ACK_TIMEOUT_NS = 2000;
	localparam int DIO_ACK_TIMEOUT_CYC = DIO_ACK_TIMEOUT_NS * DIO_CLK_MHZ / 1000;
	localparam logic [7:0] DIO_MUX_DEVICE_SELECT = 8'h7f;

	// Operation selects written by software.
	typedef enum logic [2:0] {
		DIO_OP_READ = 3'h0,
		DIO_OP_WRITE = 3'h1,
		DIO_OP_START = 3'h2,
		DIO_OP_CONTROL = 3'h3,
		DIO_OP_MASK = 3'h4,
		DIO_OP_TEST = 3'h5,
		DIO_OP_SETINT = 3'h6
	} dio_op_t;

	// Signals driven toward the controllers.
	typedef struct packed {
		logic strobe;
		logic [2:0] bus_command_code;
		logic [7:0] device_select;
		logic [15:0] bus_data_lines;
		logic bus_data_parity;
	} dio_bus_out_t;

	// Signals returned by the addressed controller.
	typedef struct packed {
		logic ack;
		logic [15:0] bus_data_lines;
	} dio_bus_in_t;

endpackage : dio_pkg

// [verilog/dio_ack_timer.sv]
// Acknowledge timer for the direct I/O command issuer.
// Assumes start and ack are synchronous to clk_sys.
`timescale 1ns/10ps
module dio_ack_timer #(
	parameter int CYCLES = dio_pkg::DIO_ACK_TIMEOUT_CYC
) (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic start,
	input wire logic run,
	output logic expired
);

	// Wide enough for the default count; a shorter count just uses fewer bits.
	logic [15:0] count;

	////////////////////////////////////////////////////////////////////////
	// Count cycles while waiting; expired pulses once the wait has run out.
	always_ff @(posedge clk_sys) begin
		if (rst || start) begin
			count <= 16'h0000;
			expired <= 1'b0;
		end else if (run) begin
			count <= count + 16'h0001;
			expired <= (count == 16'(CYCLES - 1));
		end else begin
			expired <= 1'b0;
		end
	end

endmodule : dio_ack_timer

// [tb/dio_ctrl_model.sv]
// Behavioural model of one device controller on the direct I/O bus.
// Assumes the issuer drives bus_out from clk_sys and samples bus_in on clk_sys.
`timescale 1ns/10ps
module dio_ctrl_model #(
	parameter logic [7:0] DEV = 8'h2a,
	parameter int MBIT = 5
) (
	input wire logic clk_sys,
	input wire logic rst,
	input wire dio_pkg::dio_bus_out_t bus_out,
	output dio_pkg::dio_bus_in_t bus_in,
	input wire logic present,
	input wire logic [3:0] wait_cyc,
	input wire logic [15:0] status,
	input wire logic [15:0] rdata,
	output logic [2:0] last_cmd,
	output logic [15:0] last_data,
	output logic irq_req,
	output logic mask_ff,
	output int n_cmds
);
	////////////////////////////////////////////////////////////////
	logic [3:0] age; // Cycles the current command has waited for us.
	logic prev_strobe; // Strobe one cycle ago, to count commands.
	logic active; // Interrupt active state.
	logic [15:0] last_out; // Last word we returned.
	wire logic [2:0] cmd = bus_out.bus_command_code;
	// Mask broadcasts reach every controller; other commands need our number.
	wire logic hit = bus_out.strobe && present && (bus_out.device_select == DEV || cmd == dio_pkg::DIO_CMD_MASK);
	wire logic ack_now = hit && (age >= wait_cyc);
	// Released lines show the inverse of the last value so a stale copy is never mistaken for data.
	wire logic [15:0] data_drv = !ack_now ? ~last_out : (cmd == dio_pkg::DIO_CMD_TEST) ? status :
		(cmd == dio_pkg::DIO_CMD_READ) ? rdata : ~last_out;
	// One driver for the whole returned struct.
	assign bus_in = {ack_now, data_drv};
	////////////////////////////////////////////////////////////////
	// The controller records what it was sent and updates its flip-flops.
	always_ff @(posedge clk_sys) begin
		prev_strobe <= bus_out.strobe;
		if (rst) begin
			age <= 4'h0;
			n_cmds <= 0;
			last_out <= 16'h0000;
			last_cmd <= 3'h0;
			last_data <= 16'h0000;
			irq_req <= 1'b0;
			mask_ff <= 1'b0;
			active <= 1'b0;
		end else begin
			age <= (bus_out.strobe && !ack_now) ? age + 4'h1 : 4'h0;
			if (bus_out.strobe && !prev_strobe) begin
				n_cmds <= n_cmds + 1;
			end
			if (ack_now) begin
				last_cmd <= cmd;
				last_out <= bus_in.bus_data_lines;
				if (cmd == dio_pkg::DIO_CMD_WRITE || cmd == dio_pkg::DIO_CMD_CONTROL || cmd == dio_pkg::DIO_CMD_MASK) begin
					last_data <= bus_out.bus_data_lines;
				end
				if (cmd == dio_pkg::DIO_CMD_MASK) begin
					mask_ff <= bus_out.bus_data_lines[MBIT];
				end
				if (cmd == dio_pkg::DIO_CMD_SETINT) begin
					irq_req <= 1'b1;
					active <= 1'b1;
				end
				// Clearing the active state leaves the request cause alone.
				if (cmd == dio_pkg::DIO_CMD_CLRACT) begin
					active <= 1'b0;
				end
			end
		end
	end
endmodule : dio_ctrl_model

// [tb/tb_direct_io_command_issuer.sv]
// Self-checking bench for the direct I/O command issuer.
// Assumes one clock and an AHB-Lite master modelled by tasks here.
`timescale 1ns/10ps
module tb_direct_io_command_issuer;
	logic clk_sys, rst, hwrite, hsel, hreadyout, hresp, ext_int_enable, present, irq_req, mask_ff;
	logic [31:0] haddr, hwdata, hrdata, rd, rnd;
	logic [1:0] htrans;
	logic [2:0] hsize, last_cmd;
	logic [3:0] wait_cyc;
	logic [15:0] status, rdata, last_data;
	logic [2:0] code_of [7]; // Bus command expected for each operation.
	dio_pkg::dio_bus_out_t bus_out;
	dio_pkg::dio_bus_in_t bus_in;
	int miscompares, checks_done, n_cmds;
	localparam logic [7:0] DEV = 8'h2a;
	dio_issuer #(.ACK_CYCLES(8)) dio_issuer_inst(.clk_sys, .rst, .haddr, .htrans, .hwrite, .hsize, .hsel,
		.hready(hreadyout), .hwdata, .hrdata, .hreadyout, .hresp, .bus_out, .bus_in, .ext_int_enable);
	dio_ctrl_model #(.DEV(DEV), .MBIT(5)) dio_ctrl_model_inst(.clk_sys, .rst, .bus_out, .bus_in, .present,
		.wait_cyc, .status, .rdata, .last_cmd, .last_data, .irq_req, .mask_ff, .n_cmds);
	////////////////////////////////////////////////////////////////
	// Random words come from a fixed-seed shift register.
	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : lfsr
	task automatic tally_and_finish;
		if (miscompares == 0 && checks_done > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : tally_and_finish
	task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			miscompares++;
			$display("unexpected register value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk_reg
	task automatic chk_bus(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			miscompares++;
			$display("unexpected bus value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk_bus
	// One single word transfer; the wait for hready is bounded.
	task automatic ahb(input logic [7:0] a, input logic w, input logic [31:0] wd, output logic [31:0] r);
		int n;
		n = 0;
		haddr <= {24'h000000, a};
		hwrite <= w;
		htrans <= 2'h2;
		hsel <= 1'b1;
		do begin
			@(posedge clk_sys);
			n++;
		end while (hreadyout !== 1'b1 && n < 64);
		htrans <= 2'h0;
		hwdata <= wd;
		do begin
			@(posedge clk_sys);
			n++;
		end while (hreadyout !== 1'b1 && n < 64);
		r = hrdata;
		if (n >= 64) begin
			miscompares++;
			tally_and_finish;
		end
	endtask : ahb
	////////////////////////////////////////////////////////////////
	// One instruction under one controller behaviour, checked against the model.
	task automatic run_case(input int op, input int c);
		logic [31:0] r, top, skw;
		logic [15:0] st, rw, pw;
		logic [1:0] cc;
		logic rdy, runs, pop, pv;
		int n, n0;
		rnd = lfsr(rnd);
		top = rnd;
		rnd = lfsr(rnd);
		skw = {rnd[31:8], DEV};
		rnd = lfsr(rnd);
		// Not ready sets the other ready bit, so the wrong bit choice shows up.
		st = (c == 1) ? ((rnd[15:0] & 16'h3fff) | ((op == 2) ? 16'h4000 : 16'h8000)) : (rnd[15:0] | 16'hc000);
		rw = rnd[31:16];
		present <= (c != 2);
		wait_cyc <= (c == 3) ? 4'h3 : 4'h0;
		status <= st;
		rdata <= rw;
		ahb(dio_pkg::DIO_OFF_STACK_TOP, 1'b1, top, r);
		ahb(dio_pkg::DIO_OFF_STACK_K, 1'b1, skw, r);
		ahb(dio_pkg::DIO_OFF_CMD, 1'b1, 32'h00000020, r);
		n0 = n_cmds;
		ahb(dio_pkg::DIO_OFF_CMD, 1'b1, {1'b1, 26'h0000000, c != 4, 1'b0, 3'(op)}, r);
		n = 0;
		do begin
			ahb(dio_pkg::DIO_OFF_RESULT, 1'b0, 32'h0, r);
			n++;
		end while (r[3] !== 1'b0 && n < 100);
		if (n >= 100) begin
			miscompares++;
			tally_and_finish;
		end
		runs = !(op >= 3 && c == 4);
		rdy = (c != 1) || (op >= 3);
		cc = (!runs || c == 2) ? dio_pkg::DIO_CC_LESS : !rdy ? dio_pkg::DIO_CC_GREATER : dio_pkg::DIO_CC_EQUAL;
		pop = runs && c != 2 && rdy && op >= 1 && op <= 4;
		pv = runs && c != 2 && (!rdy || op == 0 || op == 5);
		pw = (!rdy || op == 5) ? st : rw;
		chk_reg(r[2:0], {pop, cc});
		chk_bus(n_cmds != n0, runs);
		ahb(dio_pkg::DIO_OFF_PUSH, 1'b0, 32'h0, r);
		chk_reg(r[16], pv);
		if (pv) chk_reg(r[15:0], pw);
		if (cc == dio_pkg::DIO_CC_EQUAL) chk_bus(last_cmd, code_of[op]);
		if (cc == dio_pkg::DIO_CC_EQUAL && op >= 1 && op <= 4 && op != 2) chk_bus(last_data, top[15:0]);
		if (op == 4) begin
			chk_bus(ext_int_enable, c != 2);
			ahb(dio_pkg::DIO_OFF_MASK, 1'b0, 32'h0, r);
			if (cc == dio_pkg::DIO_CC_EQUAL) chk_reg(r[15:0], top[15:0]);
			if (cc == dio_pkg::DIO_CC_EQUAL) chk_bus(mask_ff, top[5]);
		end
		if (op == 2 && cc == dio_pkg::DIO_CC_EQUAL) begin
			ahb(dio_pkg::DIO_OFF_TABLE, 1'b0, 32'h0, r);
			chk_reg(r, {6'h00, DEV, 2'h0, top[15:0]});
		end
		if (op == 6 && cc == dio_pkg::DIO_CC_EQUAL) chk_bus(irq_req, 1'b1);
	endtask : run_case
	////////////////////////////////////////////////////////////////
	// Data parity must be odd whenever a command is on the bus; a mask goes to the multiplexer number.
	always @(posedge clk_sys) begin
		if (rst === 1'b0 && bus_out.strobe === 1'b1) chk_bus(^{bus_out.bus_data_lines, bus_out.bus_data_parity}, 1'b1);
		if (rst === 1'b0 && bus_out.strobe === 1'b1 && bus_out.bus_command_code === dio_pkg::DIO_CMD_MASK) begin
			chk_bus(bus_out.device_select, dio_pkg::DIO_MUX_DEVICE_SELECT);
		end
	end
	initial begin
		clk_sys = 1'b0;
		forever #4 clk_sys = ~clk_sys;
	end
	// Cases: ready, not ready, silent, slow, unprivileged.
	initial begin
		rst = 1'b1;
		haddr = 32'h0;
		htrans = 2'h0;
		hwrite = 1'b0;
		hsize = 3'h2;
		hsel = 1'b0;
		hwdata = 32'h0;
		present = 1'b0;
		wait_cyc = 4'h0;
		status = 16'h0000;
		rdata = 16'h0000;
		rnd = 32'h8d157196;
		miscompares = 0;
		checks_done = 0;
		code_of = '{dio_pkg::DIO_CMD_READ, dio_pkg::DIO_CMD_WRITE, dio_pkg::DIO_CMD_START,
			dio_pkg::DIO_CMD_CONTROL, dio_pkg::DIO_CMD_MASK, dio_pkg::DIO_CMD_TEST, dio_pkg::DIO_CMD_SETINT};
		repeat (4) @(posedge clk_sys);
		rst <= 1'b0;
		@(posedge clk_sys);
		ahb(dio_pkg::DIO_OFF_MASK, 1'b0, 32'h0, rd);
		chk_reg(rd[15:0], dio_pkg::DIO_MASK_RESET);
		chk_bus(ext_int_enable, dio_pkg::DIO_EXT_RESET);
		for (int op = 0; op < 7; op++) begin
			for (int c = 0; c < 5; c++) begin
				run_case(op, c);
			end
		end
		tally_and_finish;
	end
endmodule : tb_direct_io_command_issuer
